// File: crr_result_bank.sv
/*
 * read-only bank of conversion result registers with pair select control
 * assumes results arrive as one-cycle strobes from the core clock domain
 * and a host port whose read data is taken one cycle after the strobe
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module crr_result_bank
    import crr_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire crr_bus_req_t busReq,
    output logic [7:0] rdData,
    input wire crr_result_t result,
    output logic [1:0] inputPairSelect,
    output logic supplyLoaded
);

    logic [1:0] inputPairSelect_r;
    logic supplyLoaded_r;
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic [CRR_NUM_SLOTS-1:0] loadVec;
    logic [7:0] highBits [CRR_NUM_SLOTS];
    logic [1:0] lowBits [CRR_NUM_SLOTS];
    logic [7:0] lowRegA;
    logic [7:0] lowRegB;
    logic bankAddr;

    // maps a channel to its storage slot; ext and input one share one
    function automatic logic [3:0] chanSlot(input crr_chan_t ch);
        logic [3:0] s;
        s = CRR_SLOT_NONE;
        case (ch)
            CRR_CH_SUPPLY: s = CRR_SLOT_SUPPLY;
            CRR_CH_ITEMP: s = CRR_SLOT_ITEMP;
            CRR_CH_EXT: s = CRR_SLOT_PAIR;
            CRR_CH_ANALOG_IN_ONE: s = CRR_SLOT_PAIR;
            CRR_CH_ANALOG_IN_TWO, CRR_CH_ANALOG_IN_THREE, CRR_CH_ANALOG_IN_FOUR,
            CRR_CH_ANALOG_IN_FIVE, CRR_CH_ANALOG_IN_SIX, CRR_CH_ANALOG_IN_SEVEN,
            CRR_CH_ANALOG_IN_EIGHT: s = 4'(ch - CRR_CH_ANALOG_IN_TWO) + CRR_SLOT_ANALOG_IN_TWO;
            default: s = CRR_SLOT_NONE;
        endcase
        return s;
    endfunction

    // the shared slot only takes the source the select field names
    function automatic logic accepts(input crr_chan_t ch,
                                     input logic [1:0] sel);
        logic ok;
        ok = 1'b1;
        if (ch == CRR_CH_EXT)
            ok = (sel == CRR_SEL_EXT);
        else if (ch == CRR_CH_ANALOG_IN_ONE)
            ok = (sel == CRR_SEL_AIN);
        return ok;
    endfunction

    function automatic logic isBankAddr(input logic [7:0] a);
        return (a >= CRR_ADDR_LOW_A) && (a <= CRR_ADDR_ANALOG_IN_EIGHT);
    endfunction

    // pair select routes ext or input one
    always_comb
    begin
        for (int i = 0; i < CRR_NUM_SLOTS; i++)
        begin
            loadVec[i] = result.valid
                && accepts(result.chan, inputPairSelect_r)
                && (chanSlot(result.chan) == 4'(i));
        end
    end

    genvar g;
    generate
        for (g = 0; g < CRR_NUM_SLOTS; g++)
        begin : g_slot
            crr_result_slot #(
                .HAS_RESET(g != int'(CRR_SLOT_SUPPLY))
            ) u_slot (
                .clk(clk),
                .srst(srst),
                .load(loadVec[g]),
                .value(result.value),
                .highBits(highBits[g]),
                .lowBits(lowBits[g])
            );
        end
    endgenerate

    // shared slot and inputs two to four, shared slot in the lowest bits
    assign lowRegA = {lowBits[CRR_SLOT_ANALOG_IN_TWO + 4'h2],
                      lowBits[CRR_SLOT_ANALOG_IN_TWO + 4'h1],
                      lowBits[CRR_SLOT_ANALOG_IN_TWO],
                      lowBits[CRR_SLOT_PAIR]};
    assign lowRegB = {lowBits[CRR_SLOT_ANALOG_IN_FIVE + 4'h3],
                      lowBits[CRR_SLOT_ANALOG_IN_FIVE + 4'h2],
                      lowBits[CRR_SLOT_ANALOG_IN_FIVE + 4'h1],
                      lowBits[CRR_SLOT_ANALOG_IN_FIVE]};

    assign bankAddr = isBankAddr(busReq.addr);

    // only the select register is writable
    always_ff @(posedge clk)
    begin
        if (srst)
            inputPairSelect_r <= CRR_SEL_RESET;
        else if (busReq.wrEn && busReq.addr == CRR_ADDR_CTRL)
            inputPairSelect_r <= busReq.wrData[CRR_SEL_LSB +: 2];
    end

    // supply slot holds garbage until the first measurement lands
    always_ff @(posedge clk)
    begin
        if (srst)
            supplyLoaded_r <= 1'b0;
        else if (loadVec[CRR_SLOT_SUPPLY])
            supplyLoaded_r <= 1'b1;
    end

    // both low-bit registers, upper bits of every slot and the select field
    always_comb
    begin
        rdData_nxt = CRR_READ_IDLE;
        case (busReq.addr)
            CRR_ADDR_LOW_A: rdData_nxt = lowRegA;
            CRR_ADDR_LOW_B: rdData_nxt = lowRegB;
            CRR_ADDR_SUPPLY:
                rdData_nxt = supplyLoaded_r ?
                    highBits[CRR_SLOT_SUPPLY] : CRR_READ_IDLE;
            CRR_ADDR_ITEMP: rdData_nxt = highBits[CRR_SLOT_ITEMP];
            CRR_ADDR_PAIR: rdData_nxt = highBits[CRR_SLOT_PAIR];
            CRR_ADDR_ANALOG_IN_TWO: rdData_nxt = highBits[CRR_SLOT_ANALOG_IN_TWO];
            CRR_ADDR_ANALOG_IN_THREE: rdData_nxt = highBits[CRR_SLOT_ANALOG_IN_TWO + 4'h1];
            CRR_ADDR_ANALOG_IN_FOUR: rdData_nxt = highBits[CRR_SLOT_ANALOG_IN_TWO + 4'h2];
            CRR_ADDR_CTRL:
                rdData_nxt = 8'({inputPairSelect_r, 1'b0});
            default:
                if (busReq.addr >= CRR_ADDR_ANALOG_IN_FIVE
                    && busReq.addr <= CRR_ADDR_ANALOG_IN_EIGHT)
                    rdData_nxt = highBits[CRR_SLOT_ANALOG_IN_FIVE
                        + 4'(busReq.addr - CRR_ADDR_ANALOG_IN_FIVE)];
                else
                    rdData_nxt = CRR_READ_IDLE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (srst)
            rdData_r <= CRR_READ_IDLE;
        else if (busReq.rdEn)
            rdData_r <= rdData_nxt;
        else
            rdData_r <= CRR_READ_IDLE;
    end

    assign rdData = rdData_r;
    assign inputPairSelect = inputPairSelect_r;
    assign supplyLoaded = supplyLoaded_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence rdAt(logic [7:0] a);
        busReq.rdEn && busReq.addr == a;
    endsequence

    sequence storeOf(crr_chan_t c);
        result.valid && result.chan == c;
    endsequence

    sequence idleResult;
        !result.valid;
    endsequence

    // a host strobe lands two cycles after a store at the earliest
    sequence quietRd(logic [7:0] a);
        idleResult [*2] ##0 rdAt(a);
    endsequence

    lowRegA_a: assert property (
        rdAt(CRR_ADDR_LOW_A) |=> rdData == $past(lowRegA))
        else $error("04h read mismatch");

    lowInputs_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_THREE) ##1 quietRd(CRR_ADDR_LOW_A)
        |=> rdData[5:4] == $past(result.value[1:0], 3))
        else $error("input three low bits wrong in 04h");

    lowRegB_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_SIX) ##1 quietRd(CRR_ADDR_LOW_B)
        |=> rdData[3:2] == $past(result.value[1:0], 3))
        else $error("input six low bits wrong in 05h");

    upperFive8_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_EIGHT) ##1 quietRd(CRR_ADDR_ANALOG_IN_EIGHT)
        |=> rdData == $past(result.value[9:2], 3))
        else $error("input eight upper bits wrong");

    supplyLoad_a: assert property (
        storeOf(CRR_CH_SUPPLY) |=> supplyLoaded
            && highBits[CRR_SLOT_SUPPLY] == $past(result.value[9:2]))
        else $error("supply result not loaded");

    itempUpper_a: assert property (
        storeOf(CRR_CH_ITEMP) ##1 quietRd(CRR_ADDR_ITEMP)
        |=> rdData == $past(result.value[9:2], 3))
        else $error("internal temperature upper bits wrong");

    pairUpper_a: assert property (
        storeOf(CRR_CH_EXT) ##0 (inputPairSelect == CRR_SEL_EXT)
        |=> highBits[CRR_SLOT_PAIR] == $past(result.value[9:2]))
        else $error("external temperature not stored when selected");

    ain2Upper_a: assert property (
        rdAt(CRR_ADDR_ANALOG_IN_TWO) |=> rdData == $past(highBits[CRR_SLOT_ANALOG_IN_TWO]))
        else $error("09h read mismatch");

    ain3Upper_a: assert property (
        rdAt(CRR_ADDR_ANALOG_IN_THREE)
        |=> rdData == $past(highBits[CRR_SLOT_ANALOG_IN_TWO + 4'h1]))
        else $error("0Ah read mismatch");

    ain4Upper_a: assert property (
        rdAt(CRR_ADDR_ANALOG_IN_FOUR)
        |=> rdData == $past(highBits[CRR_SLOT_ANALOG_IN_TWO + 4'h2]))
        else $error("0Bh read mismatch");

    bitOrder_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_TWO)
        |=> {highBits[CRR_SLOT_ANALOG_IN_TWO], lowBits[CRR_SLOT_ANALOG_IN_TWO]}
            == $past(result.value))
        else $error("result bit order broken");

    resetZero_a: assert property (
        disable iff (1'b0)
        srst |=> highBits[CRR_SLOT_ITEMP] == 8'h00
            && highBits[CRR_SLOT_PAIR] == 8'h00
            && lowRegA == 8'h00 && lowRegB == 8'h00
            && !supplyLoaded)
        else $error("result not zero after reset");

    pairGate_a: assert property (
        storeOf(CRR_CH_EXT) ##0 (inputPairSelect == CRR_SEL_AIN)
        |=> $stable(highBits[CRR_SLOT_PAIR])
            && $stable(lowBits[CRR_SLOT_PAIR]))
        else $error("external result leaked into input one slot");

    writeIgnored_a: assert property (
        busReq.wrEn && bankAddr ##0 idleResult
        |=> $stable(lowRegA) && $stable(lowRegB)
            && $stable(highBits[CRR_SLOT_ITEMP]))
        else $error("host write changed a result");

    readWindow_a: assert property (
        !busReq.rdEn |=> rdData == CRR_READ_IDLE)
        else $error("read data outside its cycle");

    ctrlWrite_a: assert property (
        busReq.wrEn && busReq.addr == CRR_ADDR_CTRL
        |=> inputPairSelect == $past(busReq.wrData[CRR_SEL_LSB +: 2]))
        else $error("select field not taken from the write");

    ctrlRead_a: assert property (
        rdAt(CRR_ADDR_CTRL)
        |=> rdData == {5'h00, $past(inputPairSelect), 1'h0})
        else $error("select field read back wrong");

    ctrlKeep_a: assert property (
        busReq.wrEn && bankAddr |=> $stable(inputPairSelect))
        else $error("result bank write changed the select field");

    ain1Store_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_ONE) ##0 (inputPairSelect == CRR_SEL_AIN)
        |=> {highBits[CRR_SLOT_PAIR], lowBits[CRR_SLOT_PAIR]}
            == $past(result.value))
        else $error("input one not stored when selected");

    ain1Gate_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_ONE) ##0 (inputPairSelect == CRR_SEL_EXT)
        |=> $stable(highBits[CRR_SLOT_PAIR])
            && $stable(lowBits[CRR_SLOT_PAIR]))
        else $error("input one leaked into external slot");

    // undefined codes must not let either source through
    undefKeep_a: assert property (
        result.valid && inputPairSelect != CRR_SEL_AIN
            && inputPairSelect != CRR_SEL_EXT
        |=> $stable(highBits[CRR_SLOT_PAIR])
            && $stable(lowBits[CRR_SLOT_PAIR]))
        else $error("shared slot changed under an undefined code");

    supplyGate_a: assert property (
        rdAt(CRR_ADDR_SUPPLY) ##0 !supplyLoaded
        |=> rdData == CRR_READ_IDLE)
        else $error("supply read before first measurement not zero");

    supplyRead_a: assert property (
        rdAt(CRR_ADDR_SUPPLY) ##0 supplyLoaded
        |=> rdData == $past(highBits[CRR_SLOT_SUPPLY]))
        else $error("06h read mismatch");

    supplyHeld_a: assert property (
        supplyLoaded |=> supplyLoaded)
        else $error("supply loaded flag dropped without reset");

    lowBRead_a: assert property (
        rdAt(CRR_ADDR_LOW_B) |=> rdData == $past(lowRegB))
        else $error("05h read mismatch");

    ain5Upper_a: assert property (
        rdAt(CRR_ADDR_ANALOG_IN_FIVE)
        |=> rdData == $past(highBits[CRR_SLOT_ANALOG_IN_FIVE]))
        else $error("0Ch read mismatch");

    ain5Order_a: assert property (
        storeOf(CRR_CH_ANALOG_IN_FIVE)
        |=> {highBits[CRR_SLOT_ANALOG_IN_FIVE], lowBits[CRR_SLOT_ANALOG_IN_FIVE]}
            == $past(result.value))
        else $error("input five bit order broken");

    itempRead_a: assert property (
        rdAt(CRR_ADDR_ITEMP)
        |=> rdData == $past(highBits[CRR_SLOT_ITEMP]))
        else $error("07h read mismatch");

    itempOrder_a: assert property (
        storeOf(CRR_CH_ITEMP)
        |=> {highBits[CRR_SLOT_ITEMP], lowBits[CRR_SLOT_ITEMP]}
            == $past(result.value))
        else $error("internal temperature not stored as given");

    pairRead_a: assert property (
        rdAt(CRR_ADDR_PAIR) |=> rdData == $past(highBits[CRR_SLOT_PAIR]))
        else $error("08h read mismatch");

    // reads outside the bank and the select register idle at zero
    unmappedRead_a: assert property (
        busReq.rdEn && !bankAddr && busReq.addr != CRR_ADDR_CTRL
        |=> rdData == CRR_READ_IDLE)
        else $error("unmapped read returned data");

endmodule

// File: crr_pkg.sv
/*
 * shared constants and types for the conversion result register bank
 * assumes one core clock, a synchronous reset and an 8-bit register port
 */
package crr_pkg;

    localparam logic [7:0] CRR_ADDR_LOW_A = 8'h04;
    localparam logic [7:0] CRR_ADDR_LOW_B = 8'h05;
    localparam logic [7:0] CRR_ADDR_SUPPLY = 8'h06;
    localparam logic [7:0] CRR_ADDR_ITEMP = 8'h07;
    localparam logic [7:0] CRR_ADDR_PAIR = 8'h08;
    localparam logic [7:0] CRR_ADDR_ANALOG_IN_TWO = 8'h09;
    localparam logic [7:0] CRR_ADDR_ANALOG_IN_THREE = 8'h0a;
    localparam logic [7:0] CRR_ADDR_ANALOG_IN_FOUR = 8'h0b;
    localparam logic [7:0] CRR_ADDR_ANALOG_IN_FIVE = 8'h0c;
    localparam logic [7:0] CRR_ADDR_ANALOG_IN_EIGHT = 8'h0f;
    localparam logic [7:0] CRR_ADDR_CTRL = 8'h18;

    localparam int CRR_SEL_LSB = 1;
    localparam logic [1:0] CRR_SEL_AIN = 2'h0;
    localparam logic [1:0] CRR_SEL_EXT = 2'h2;
    localparam logic [1:0] CRR_SEL_RESET = 2'h0;

    localparam logic [9:0] CRR_RESULT_RESET = 10'h000;
    localparam logic [7:0] CRR_READ_IDLE = 8'h00;

    localparam int CRR_NUM_SLOTS = 10;
    localparam logic [3:0] CRR_SLOT_SUPPLY = 4'h0;
    localparam logic [3:0] CRR_SLOT_ITEMP = 4'h1;
    localparam logic [3:0] CRR_SLOT_PAIR = 4'h2;
    localparam logic [3:0] CRR_SLOT_ANALOG_IN_TWO = 4'h3;
    localparam logic [3:0] CRR_SLOT_ANALOG_IN_FIVE = 4'h6;
    localparam logic [3:0] CRR_SLOT_NONE = 4'hf;

    typedef enum logic [3:0] {
        CRR_CH_SUPPLY = 4'h0,
        CRR_CH_ITEMP = 4'h1,
        CRR_CH_EXT = 4'h2,
        CRR_CH_ANALOG_IN_ONE = 4'h3,
        CRR_CH_ANALOG_IN_TWO = 4'h4,
        CRR_CH_ANALOG_IN_THREE = 4'h5,
        CRR_CH_ANALOG_IN_FOUR = 4'h6,
        CRR_CH_ANALOG_IN_FIVE = 4'h7,
        CRR_CH_ANALOG_IN_SIX = 4'h8,
        CRR_CH_ANALOG_IN_SEVEN = 4'h9,
        CRR_CH_ANALOG_IN_EIGHT = 4'ha
    } crr_chan_t;

    typedef struct packed {
        logic valid;
        crr_chan_t chan;
        logic [9:0] value;
    } crr_result_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } crr_bus_req_t;

endpackage

// File: crr_result_slot.sv
/*
 * one stored 10-bit conversion result, split into upper and low bits
 * assumes load is a one-cycle strobe from logic on the same clock
 */
`timescale 1ns/1ps
module crr_result_slot
    import crr_pkg::*;
#(
    parameter bit HAS_RESET = 1'b1
)
(
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [9:0] value,
    output logic [7:0] highBits,
    output logic [1:0] lowBits
);

    logic [9:0] value_r;

    generate
        if (HAS_RESET)
        begin : g_rst
            always_ff @(posedge clk)
            begin
                if (srst)
                    value_r <= CRR_RESULT_RESET;
                else if (load)
                    value_r <= value;
            end
        end
        else
        begin : g_norst
            always_ff @(posedge clk)
            begin
                if (load)
                    value_r <= value;
            end
        end
    endgenerate

    assign highBits = value_r[9:2];
    assign lowBits = value_r[1:0];

endmodule

// File: test_conversion_result_registers.sv
/*
 * self-checking bench for the conversion result register bank
 * assumes crr_pkg and crr_result_bank are compiled first; the bench
 * drives the register port and the result strobe itself
 */
`timescale 1ns/1ps
module test_conversion_result_registers
    import crr_pkg::*;
;
    logic clk;
    logic srst;
    crr_bus_req_t busReq;
    crr_result_t result;
    logic [7:0] rdData;
    logic [1:0] inputPairSelect;
    logic supplyLoaded;
    int errors;
    int comparisons;
    int cycles;
    // expected result per channel code; index 2 and 3 unused
    logic [9:0] vals [0:10];
    // shared slot of external temperature and input one
    logic [9:0] pairVal;

    crr_result_bank i_dut (
        .clk(clk),
        .srst(srst),
        .busReq(busReq),
        .rdData(rdData),
        .result(result),
        .inputPairSelect(inputPairSelect),
        .supplyLoaded(supplyLoaded)
    );

    always #50 clk = ~clk;

    task end_of_test;
        if (errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            $display("[FAIL] %0t run timed out", $time);
            end_of_test;
        end
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq.wrEn <= 1'b1;
        busReq.addr <= a;
        busReq.wrData <= d;
        @(posedge clk);
        busReq.wrEn <= 1'b0;
    endtask

    // read data stands one cycle only, then idles at zero
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        busReq.rdEn <= 1'b1;
        busReq.addr <= a;
        @(posedge clk);
        busReq.rdEn <= 1'b0;
        #1;
        check(rdData, exp);
        @(posedge clk);
        #1;
        check(rdData, CRR_READ_IDLE);
    endtask

    task store(input crr_chan_t ch, input logic [9:0] v, input bit taken);
        @(posedge clk);
        result <= '{1'b1, ch, v};
        @(posedge clk);
        result.valid <= 1'b0;
        if (taken && (ch == CRR_CH_EXT || ch == CRR_CH_ANALOG_IN_ONE))
            pairVal = v;
        else if (taken)
            vals[ch] = v;
    endtask

    function automatic logic [7:0] expReg(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == CRR_ADDR_LOW_A)
            r = {vals[6][1:0], vals[5][1:0], vals[4][1:0], pairVal[1:0]};
        else if (a == CRR_ADDR_LOW_B)
            r = {vals[10][1:0], vals[9][1:0], vals[8][1:0], vals[7][1:0]};
        else if (a == CRR_ADDR_SUPPLY)
            r = vals[0][9:2];
        else if (a == CRR_ADDR_ITEMP)
            r = vals[1][9:2];
        else if (a == CRR_ADDR_PAIR)
            r = pairVal[9:2];
        else if (a >= CRR_ADDR_ANALOG_IN_TWO && a <= CRR_ADDR_ANALOG_IN_EIGHT)
            r = vals[a - 8'h05][9:2];
        return r;
    endfunction

    // supply may be skipped: its storage survives a reset
    task check_all(input bit skipSup);
        for (int a = 4; a <= 15; a++)
        begin
            if (!(skipSup && a == 6))
                rd(8'(a), expReg(8'(a)));
        end
    endtask

    initial
    begin
        clk = 1'b0;
        srst = 1'b1;
        busReq = '0;
        result = '0;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        pairVal = '0;
        for (int i = 0; i <= 10; i++)
            vals[i] = '0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        check_all(1'b0);
        check({6'h00, inputPairSelect}, 8'h00);
        check({7'h00, supplyLoaded}, 8'h00);
        // bit placement, external result dropped under select 00
        for (int c = 1; c <= 10; c++)
            store(crr_chan_t'(c), 10'h3a5 ^ 10'(c * 123), c != 2);
        check_all(1'b0);
        for (int a = 4; a <= 15; a++)
            wr(8'(a), 8'hff);
        check_all(1'b0);
        // external sensor picked by code 10
        wr(CRR_ADDR_CTRL, 8'h04);
        #1;
        check({6'h00, inputPairSelect}, 8'h02);
        rd(CRR_ADDR_CTRL, 8'h04);
        store(CRR_CH_EXT, 10'h2c1, 1'b1);
        store(CRR_CH_ANALOG_IN_ONE, 10'h0ff, 1'b0);
        check_all(1'b0);
        // undefined codes keep the shared slot
        wr(CRR_ADDR_CTRL, 8'h02);
        store(CRR_CH_EXT, 10'h111, 1'b0);
        store(CRR_CH_ANALOG_IN_ONE, 10'h222, 1'b0);
        wr(CRR_ADDR_CTRL, 8'h06);
        store(CRR_CH_EXT, 10'h333, 1'b0);
        store(CRR_CH_ANALOG_IN_ONE, 10'h044, 1'b0);
        check_all(1'b0);
        wr(CRR_ADDR_CTRL, 8'h00);
        store(CRR_CH_EXT, 10'h155, 1'b0);
        store(CRR_CH_ANALOG_IN_ONE, 10'h1e6, 1'b1);
        check_all(1'b0);
        store(CRR_CH_SUPPLY, 10'h2e7, 1'b1);
        #1;
        check({7'h00, supplyLoaded}, 8'h01);
        // boundary values, some read back right after their store
        store(CRR_CH_ANALOG_IN_EIGHT, 10'h3ff, 1'b1);
        rd(CRR_ADDR_ANALOG_IN_EIGHT, expReg(CRR_ADDR_ANALOG_IN_EIGHT));
        store(CRR_CH_ANALOG_IN_FIVE, 10'h000, 1'b1);
        store(CRR_CH_ITEMP, 10'h200, 1'b1);
        rd(CRR_ADDR_ITEMP, expReg(CRR_ADDR_ITEMP));
        store(CRR_CH_ANALOG_IN_THREE, 10'h2b6, 1'b1);
        rd(CRR_ADDR_LOW_A, expReg(CRR_ADDR_LOW_A));
        store(CRR_CH_ANALOG_IN_SIX, 10'h0c9, 1'b1);
        rd(CRR_ADDR_LOW_B, expReg(CRR_ADDR_LOW_B));
        check_all(1'b0);
        rd(8'h10, 8'h00);
        rd(8'h03, 8'h00);
        // second reset in mid-run, select field set beforehand
        wr(CRR_ADDR_CTRL, 8'h04);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        pairVal = '0;
        for (int i = 1; i <= 10; i++)
            vals[i] = '0;
        #1;
        check({7'h00, supplyLoaded}, 8'h00);
        check({6'h00, inputPairSelect}, 8'h00);
        check_all(1'b1);
        // supply reads zero again until a fresh measurement lands
        rd(CRR_ADDR_SUPPLY, 8'h00);
        store(CRR_CH_SUPPLY, 10'h0d4, 1'b1);
        rd(CRR_ADDR_SUPPLY, expReg(CRR_ADDR_SUPPLY));
        end_of_test;
    end
endmodule
